//--- src/load_store_multiple_exec.sv
// Execution unit for single, two-word, multiple and stack memory transfers.
// Assumes the core reads registers through a same-cycle port and the bus answers with ready.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Unprivileged forms address base plus unsigned 0..255 offset.
// - Unprivileged forms always access memory with user rights.
// - Run by user software, they match ordinary immediate-offset transfers.
// - Byte and halfword loads zero- or sign-extend to 32 bits.
// - PC-relative loads address program counter plus signed offset.
// - Word load into program counter branches with bit 0 cleared.
// - Multiple transfers default to increment-after; decrement-before also exists.
// - Increment-after walks upward by four, lowest register first.
// - Increment-after writeback is base plus four times (count minus one).
// - Decrement-before walks downward by four, highest register first.
// - Decrement-before writeback is base minus four times (count minus one).
// - Stack-style aliases map onto increment-after or decrement-before.
// - Stack save is decrement-before store, restore increment-after load, SP writeback.
// - Restore ascends lowest first; save descends highest first.
// - No transfer changes the condition flags.
// - Register offset address is base plus offset shifted by 0..3.
module load_store_multiple_exec (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Request from the decoder
   input wire logic i_req_valid,
   input wire lsm_pkg::req_t i_req,
   output logic o_req_ready,
   // Register file read port
   output logic [3:0] o_rf_rd_idx,
   input wire logic [31:0] i_rf_rd_data,
   // Register file write port, branch and flags
   output lsm_pkg::rf_wr_t o_rf_wr,
   output lsm_pkg::branch_t o_branch,
   output logic o_flags_we,
   // Memory bus
   output lsm_pkg::mem_req_t o_mem,
   input wire logic i_mem_ready,
   input wire logic [31:0] i_mem_rdata
);
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_SETUP = 2'b01,
      S_XFER = 2'b10,
      S_WB = 2'b11
   } state_t;

   state_t state_r, state_nxt;
   lsm_pkg::form_t form_r, form_nxt;
   lsm_pkg::size_t size_r, size_nxt;
   logic [lsm_pkg::NUM_REGS-1:0] list_r, list_nxt;
   logic [3:0] idx_r, idx_nxt, xfer2_r, xfer2_nxt, base_idx_r, base_idx_nxt;
   logic [31:0] addr_r, addr_nxt, wdata_r, wdata_nxt;
   logic load_r, load_nxt, desc_r, desc_nxt, wb_r, wb_nxt, second_r, second_nxt;
   logic sign_r, sign_nxt, unpriv_r, unpriv_nxt;
   lsm_pkg::rf_wr_t rf_r, rf_nxt;
   lsm_pkg::branch_t br_r, br_nxt;
   logic [2:0] dm;
   logic [3:0] pick;
   logic more;
   logic [31:0] ext_val;

   load_extend u_ext (
      .i_word(i_mem_rdata),
      .i_lane(addr_r[1:0]),
      .i_size(size_r),
      .i_signed(sign_r),
      .o_value(ext_val)
   );

   always_comb begin
      state_nxt = state_r;
      form_nxt = form_r;
      size_nxt = size_r;
      list_nxt = list_r;
      idx_nxt = idx_r;
      xfer2_nxt = xfer2_r;
      base_idx_nxt = base_idx_r;
      addr_nxt = addr_r;
      wdata_nxt = wdata_r;
      load_nxt = load_r;
      desc_nxt = desc_r;
      wb_nxt = wb_r;
      second_nxt = second_r;
      sign_nxt = sign_r;
      unpriv_nxt = unpriv_r;
      rf_nxt = '0;
      br_nxt = '0;
      dm = lsm_pkg::decode_multi(i_req.multi);
      pick = desc_r ? lsm_pkg::highest_set(list_r) : lsm_pkg::lowest_set(list_r);
      more = (form_r == lsm_pkg::F_MULTI) ? (list_r != '0) :
         ((form_r == lsm_pkg::F_TWO_WORD_LOAD) && !second_r);
      unique case (state_r)
         S_IDLE: begin
            if (i_req_valid) begin
               form_nxt = i_req.form;
               second_nxt = 1'b0;
               xfer2_nxt = i_req.xfer2_idx;
               sign_nxt = i_req.signed_ld;
               state_nxt = S_SETUP;
               if (i_req.form == lsm_pkg::F_MULTI) begin
                  load_nxt = dm[2];
                  desc_nxt = dm[1];
                  size_nxt = lsm_pkg::SZ_WORD;
                  unpriv_nxt = ~i_req.privileged;
                  base_idx_nxt = dm[0] ? lsm_pkg::REG_SP : i_req.base_idx;
                  wb_nxt = dm[0] | i_req.writeback;
                  addr_nxt = i_req.base_val;
                  idx_nxt = dm[1] ? lsm_pkg::highest_set(i_req.reglist) :
                     lsm_pkg::lowest_set(i_req.reglist);
                  list_nxt = i_req.reglist & ~(16'h0001 << idx_nxt);
               end else begin
                  load_nxt = (i_req.form != lsm_pkg::F_SINGLE_STORE);
                  desc_nxt = 1'b0;
                  wb_nxt = 1'b0;
                  list_nxt = '0;
                  idx_nxt = i_req.xfer_idx;
                  size_nxt = (i_req.form == lsm_pkg::F_TWO_WORD_LOAD) ?
                     lsm_pkg::SZ_WORD : i_req.size;
                  unpriv_nxt = (i_req.amode == lsm_pkg::AM_UNPRIV) |
                     ~i_req.privileged;
                  unique case (i_req.amode)
                     lsm_pkg::AM_UNPRIV:
                        addr_nxt = i_req.base_val + 32'(i_req.imm);
                     lsm_pkg::AM_PCREL:
                        addr_nxt = i_req.pc + 32'(signed'(i_req.pc_off));
                     lsm_pkg::AM_REGOFF:
                        addr_nxt = i_req.base_val + (i_req.offset_val << i_req.shift);
                     default: addr_nxt = i_req.base_val;
                  endcase
               end
            end
         end
         S_SETUP: begin
            wdata_nxt = i_rf_rd_data;
            state_nxt = S_XFER;
         end
         S_XFER: begin
            if (i_mem_ready) begin
               if (load_r && idx_r == lsm_pkg::REG_PC && size_r == lsm_pkg::SZ_WORD) begin
                  br_nxt.valid = 1'b1;
                  br_nxt.target = {ext_val[31:1], 1'b0};
               end else if (load_r) begin
                  rf_nxt.we = 1'b1;
                  rf_nxt.idx = idx_r;
                  rf_nxt.data = ext_val;
               end
               if (more) begin
                  state_nxt = S_SETUP;
                  if (form_r == lsm_pkg::F_MULTI) begin
                     idx_nxt = pick;
                     list_nxt = list_r & ~(16'h0001 << pick);
                     addr_nxt = desc_r ? addr_r - lsm_pkg::WORD_STEP :
                        addr_r + lsm_pkg::WORD_STEP;
                  end else begin
                     second_nxt = 1'b1;
                     idx_nxt = xfer2_r;
                     addr_nxt = addr_r + lsm_pkg::WORD_STEP;
                  end
               end else begin
                  state_nxt = wb_r ? S_WB : S_IDLE;
               end
            end
         end
         S_WB: begin
            rf_nxt.we = 1'b1;
            rf_nxt.idx = base_idx_r;
            rf_nxt.data = addr_r;
            state_nxt = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r <= S_IDLE;
         form_r <= lsm_pkg::F_SINGLE_LOAD;
         size_r <= lsm_pkg::SZ_WORD;
         list_r <= '0;
         idx_r <= 4'h0;
         xfer2_r <= 4'h0;
         base_idx_r <= 4'h0;
         addr_r <= 32'h0;
         wdata_r <= 32'h0;
         load_r <= 1'b0;
         desc_r <= 1'b0;
         wb_r <= 1'b0;
         second_r <= 1'b0;
         sign_r <= 1'b0;
         unpriv_r <= 1'b0;
         rf_r <= '0;
         br_r <= '0;
      end else begin
         state_r <= state_nxt;
         form_r <= form_nxt;
         size_r <= size_nxt;
         list_r <= list_nxt;
         idx_r <= idx_nxt;
         xfer2_r <= xfer2_nxt;
         base_idx_r <= base_idx_nxt;
         addr_r <= addr_nxt;
         wdata_r <= wdata_nxt;
         load_r <= load_nxt;
         desc_r <= desc_nxt;
         wb_r <= wb_nxt;
         second_r <= second_nxt;
         sign_r <= sign_nxt;
         unpriv_r <= unpriv_nxt;
         rf_r <= rf_nxt;
         br_r <= br_nxt;
      end
   end

   assign o_req_ready = (state_r == S_IDLE);
   assign o_rf_rd_idx = idx_r;
   assign o_rf_wr = rf_r;
   assign o_branch = br_r;
   assign o_flags_we = 1'b0;
   assign o_mem.valid = (state_r == S_XFER);
   assign o_mem.write = ~load_r;
   assign o_mem.unpriv = unpriv_r;
   assign o_mem.size = size_r;
   assign o_mem.addr = addr_r;
   assign o_mem.wdata = wdata_r;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   AST_UNPRIV_ATTR: assert property (
      (i_req_valid && o_req_ready && i_req.form != lsm_pkg::F_MULTI &&
       i_req.amode == lsm_pkg::AM_UNPRIV) |-> ##2 (o_mem.valid && o_mem.unpriv))
      else $error("unprivileged form issued without user attribute");
   AST_USER_SAME: assert property (
      (i_req_valid && o_req_ready && !i_req.privileged) |-> ##2 o_mem.unpriv)
      else $error("user software access lost its user attribute");
   AST_UNPRIV_ADDR: assert property (
      (i_req_valid && o_req_ready && i_req.form != lsm_pkg::F_MULTI &&
       i_req.amode == lsm_pkg::AM_UNPRIV) |=>
      addr_r == $past(i_req.base_val) + 32'($past(i_req.imm)))
      else $error("unprivileged address is not base plus offset");
   AST_PCREL_ADDR: assert property (
      (i_req_valid && o_req_ready && i_req.form != lsm_pkg::F_MULTI &&
       i_req.amode == lsm_pkg::AM_PCREL) |=>
      addr_r == $past(i_req.pc) + 32'(signed'($past(i_req.pc_off))))
      else $error("pc-relative address is wrong");
   AST_IA_STEP: assert property (
      (o_mem.valid && i_mem_ready && form_r == lsm_pkg::F_MULTI && !desc_r && list_r != '0)
      |=> (addr_r == $past(addr_r) + lsm_pkg::WORD_STEP && idx_r > $past(idx_r)))
      else $error("increment-after step or order is wrong");
   AST_DB_STEP: assert property (
      (o_mem.valid && i_mem_ready && form_r == lsm_pkg::F_MULTI && desc_r && list_r != '0)
      |=> (addr_r == $past(addr_r) - lsm_pkg::WORD_STEP && idx_r < $past(idx_r)))
      else $error("decrement-before step or order is wrong");
   AST_WB_VALUE: assert property (
      (o_mem.valid && i_mem_ready && wb_r && !more) |=> ##1
      (o_rf_wr.we && o_rf_wr.idx == $past(base_idx_r, 2) && o_rf_wr.data == $past(addr_r, 2)))
      else $error("writeback value is not the final transfer address");
   AST_STACK_SP: assert property (
      (i_req_valid && o_req_ready && i_req.form == lsm_pkg::F_MULTI &&
       (i_req.multi == lsm_pkg::MT_STACK_SAVE || i_req.multi == lsm_pkg::MT_STACK_RESTORE))
      |=> (base_idx_r == lsm_pkg::REG_SP && wb_r && desc_r == !load_r))
      else $error("stack transfer not based on stack pointer");
   AST_BRANCH_ALIGN: assert property (
      (o_mem.valid && i_mem_ready && load_r && idx_r == lsm_pkg::REG_PC &&
       size_r == lsm_pkg::SZ_WORD) |=> (o_branch.valid && !o_branch.target[0] &&
       o_branch.target[31:1] == $past(ext_val[31:1]) && !o_rf_wr.we))
      else $error("program counter load did not branch to halfword target");
   AST_SIGN_BYTE: assert property (
      (o_mem.valid && i_mem_ready && load_r && size_r == lsm_pkg::SZ_BYTE) |=>
      (o_rf_wr.data[31:8] == ($past(sign_r) ? {24{o_rf_wr.data[7]}} : 24'h0)))
      else $error("byte load extension is wrong");
   AST_NO_FLAGS: assert property (
      o_mem.valid |-> !o_flags_we)
      else $error("transfer touched the condition flags");

   COV_PUSH: cover property (state_r == S_WB && desc_r && base_idx_r == lsm_pkg::REG_SP);
   COV_POP_BRANCH: cover property (o_branch.valid && form_r == lsm_pkg::F_MULTI);
   COV_TWO_WORD: cover property (o_mem.valid && i_mem_ready && second_r);
   COV_UNPRIV: cover property (o_mem.valid && o_mem.unpriv && o_mem.write);

endmodule : load_store_multiple_exec
`default_nettype wire

//--- src/lsm_pkg.sv
// Shared types and constants for the load/store and multiple-transfer execution unit.
// Assumes a 16-entry register file and a word-wide memory bus on the core clock.
`default_nettype none
package lsm_pkg;

   localparam logic [3:0] REG_SP = 4'hd;
   localparam logic [3:0] REG_LINK = 4'he;
   localparam logic [3:0] REG_PC = 4'hf;
   localparam logic [31:0] WORD_STEP = 32'h0000_0004;
   localparam int NUM_REGS = 16;
   localparam int UNPRIV_IMM_W = 8;
   localparam int PCREL_OFF_W = 13;
   localparam int BYTE_W = 8;
   localparam int HALF_W = 16;

   typedef enum logic [1:0] {
      F_SINGLE_LOAD = 2'b00,
      F_SINGLE_STORE = 2'b01,
      F_TWO_WORD_LOAD = 2'b10,
      F_MULTI = 2'b11
   } form_t;

   typedef enum logic [1:0] {
      AM_UNPRIV = 2'b00,
      AM_PCREL = 2'b01,
      AM_REGOFF = 2'b10
   } amode_t;

   // Assembler spellings of the multiple-transfer family.
   typedef enum logic [3:0] {
      MT_LOAD_PLAIN = 4'h0,
      MT_LOAD_INC = 4'h1,
      MT_FD_POP = 4'h2,
      MT_LOAD_DEC = 4'h3,
      MT_EA_POP = 4'h4,
      MT_STORE_PLAIN = 4'h5,
      MT_STORE_INC = 4'h6,
      MT_EA_PUSH = 4'h7,
      MT_STORE_DEC = 4'h8,
      MT_FD_PUSH = 4'h9,
      MT_STACK_SAVE = 4'ha,
      MT_STACK_RESTORE = 4'hb
   } multi_t;

   typedef enum logic [1:0] {
      SZ_BYTE = 2'b00,
      SZ_HALF = 2'b01,
      SZ_WORD = 2'b10
   } size_t;

   typedef struct packed {
      form_t form;
      amode_t amode;
      multi_t multi;
      size_t size;
      logic signed_ld;
      logic privileged;
      logic [3:0] xfer_idx;
      logic [3:0] xfer2_idx;
      logic [3:0] base_idx;
      logic [31:0] base_val;
      logic [31:0] offset_val;
      logic [1:0] shift;
      logic [UNPRIV_IMM_W-1:0] imm;
      logic [31:0] pc;
      logic [PCREL_OFF_W-1:0] pc_off;
      logic [NUM_REGS-1:0] reglist;
      logic writeback;
   } req_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic unpriv;
      size_t size;
      logic [31:0] addr;
      logic [31:0] wdata;
   } mem_req_t;

   typedef struct packed {
      logic we;
      logic [3:0] idx;
      logic [31:0] data;
   } rf_wr_t;

   typedef struct packed {
      logic valid;
      logic [31:0] target;
   } branch_t;

   // Returns {is_load, is_decrement_before, is_stack}.
   function automatic logic [2:0] decode_multi(input multi_t m);
      unique case (m)
         MT_LOAD_PLAIN, MT_LOAD_INC, MT_FD_POP: decode_multi = 3'b100;
         MT_LOAD_DEC, MT_EA_POP: decode_multi = 3'b110;
         MT_STORE_PLAIN, MT_STORE_INC, MT_EA_PUSH: decode_multi = 3'b000;
         MT_STORE_DEC, MT_FD_PUSH: decode_multi = 3'b010;
         MT_STACK_SAVE: decode_multi = 3'b011;
         MT_STACK_RESTORE: decode_multi = 3'b101;
         default: decode_multi = 3'b100;
      endcase
   endfunction : decode_multi

   function automatic logic [3:0] lowest_set(input logic [NUM_REGS-1:0] l);
      lowest_set = 4'h0;
      for (int i = NUM_REGS - 1; i >= 0; i--) begin
         if (l[i]) lowest_set = 4'(i);
      end
   endfunction : lowest_set

   function automatic logic [3:0] highest_set(input logic [NUM_REGS-1:0] l);
      highest_set = 4'h0;
      for (int i = 0; i < NUM_REGS; i++) begin
         if (l[i]) highest_set = 4'(i);
      end
   endfunction : highest_set

endpackage : lsm_pkg
`default_nettype wire

//--- src/load_extend.sv
// Lane select and extension of a loaded memory word.
// Assumes the memory returns the whole aligned word holding the addressed bytes.
`timescale 1ns/100ps
`default_nettype none
module load_extend (
   // Loaded word and its shape
   input wire logic [31:0] i_word,
   input wire logic [1:0] i_lane,
   input wire lsm_pkg::size_t i_size,
   input wire logic i_signed,
   // Register-wide result
   output logic [31:0] o_value
);
   logic [31:0] shifted;
   logic [lsm_pkg::BYTE_W-1:0] b;
   logic [lsm_pkg::HALF_W-1:0] h;

   always_comb begin
      shifted = i_word >> {i_lane, 3'b000};
      b = shifted[lsm_pkg::BYTE_W-1:0];
      h = shifted[lsm_pkg::HALF_W-1:0];
      unique case (i_size)
         lsm_pkg::SZ_BYTE: o_value = i_signed ? 32'(signed'(b)) : 32'(b);
         lsm_pkg::SZ_HALF: o_value = i_signed ? 32'(signed'(h)) : 32'(h);
         default: o_value = i_word;
      endcase
   end
endmodule : load_extend
`default_nettype wire

//--- sim/lsm_mem_model.sv
// Behavioural memory partner on the core bus, with a stall length set by the bench.
// Assumes one bus request at a time, held by the unit until ready is seen.
`timescale 1ns/100ps
`default_nettype none
module lsm_mem_model (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Bus from the unit and stall length
   input wire lsm_pkg::mem_req_t i_mem,
   input wire logic [1:0] i_wait,
   // Answer to the unit
   output logic o_ready,
   output logic [31:0] o_rdata
);
   logic [31:0] mem [0:127];
   logic [1:0] cnt_r;

   // The bench preloads words here, so this store is a plain process.
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_ready <= 1'b0;
         cnt_r <= 2'h0;
         o_rdata <= 32'h5a5a_a5a5;
      end else if (o_ready || (i_mem.valid !== 1'b1)) begin
         // Read data is not held once the beat ends: it flips every cycle.
         o_ready <= 1'b0;
         cnt_r <= 2'h0;
         o_rdata <= ~o_rdata;
      end else if (cnt_r == i_wait) begin
         o_ready <= 1'b1;
         o_rdata <= mem[i_mem.addr[8:2]];
         if (i_mem.write) begin
            mem[i_mem.addr[8:2]] <= i_mem.wdata;
         end
      end else begin
         cnt_r <= cnt_r + 2'h1;
      end
   end
endmodule : lsm_mem_model
`default_nettype wire

//--- sim/load_store_multiple_exec_tb_top.sv
// Self-checking bench for the load/store and multiple-transfer unit.
// Assumes the memory partner model and a register file that answers in the same cycle.
`timescale 1ns/100ps
`default_nettype none
module load_store_multiple_exec_tb_top;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_req_valid = 1'b0;
   lsm_pkg::req_t i_req = '0;
   logic o_req_ready;
   logic [3:0] o_rf_rd_idx;
   logic [31:0] i_rf_rd_data;
   lsm_pkg::rf_wr_t o_rf_wr;
   lsm_pkg::branch_t o_branch;
   logic o_flags_we;
   lsm_pkg::mem_req_t o_mem;
   logic i_mem_ready;
   logic [31:0] i_mem_rdata;
   logic [1:0] stall = 2'h0;
   int mismatches = 0;
   int tests_run = 0;
   lsm_pkg::mem_req_t bq[$];
   lsm_pkg::rf_wr_t wq[$];
   logic [31:0] brq[$];
   lsm_pkg::req_t r;

   always #5 i_clk = ~i_clk;
   assign i_rf_rd_data = {28'hc0de000, o_rf_rd_idx};

   load_store_multiple_exec i_load_store_multiple_exec (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_req_valid(i_req_valid), .i_req(i_req),
      .o_req_ready(o_req_ready), .o_rf_rd_idx(o_rf_rd_idx), .i_rf_rd_data(i_rf_rd_data),
      .o_rf_wr(o_rf_wr), .o_branch(o_branch), .o_flags_we(o_flags_we), .o_mem(o_mem),
      .i_mem_ready(i_mem_ready), .i_mem_rdata(i_mem_rdata));
   lsm_mem_model i_lsm_mem_model (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_mem(o_mem), .i_wait(stall),
      .o_ready(i_mem_ready), .o_rdata(i_mem_rdata));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   always @(posedge i_clk) begin
      if ((o_mem.valid === 1'b1) && (i_mem_ready === 1'b1)) bq.push_back(o_mem);
      if (o_rf_wr.we === 1'b1) wq.push_back(o_rf_wr);
      if (o_branch.valid === 1'b1) brq.push_back(o_branch.target);
      if (o_flags_we !== 1'b0) chk("flags_we", 32'h0, {31'h0, o_flags_we});
   end

   task automatic put(input logic [31:0] a, input logic [31:0] v);
      i_lsm_mem_model.mem[a[8:2]] = v;
   endtask : put

   // Requests are issued unconditionally, so a program-counter load never sits in a
   // conditional block.
   task automatic issue(input logic [1:0] w);
      bq.delete();
      wq.delete();
      brq.delete();
      stall = w;
      i_req = r;
      i_req_valid = 1'b1;
      @(negedge i_clk);
      i_req_valid = 1'b0;
      for (int n = 0; n < 100 && o_req_ready !== 1'b1; n++) @(negedge i_clk);
      chk("req_ready", 32'h1, {31'h0, o_req_ready});
      @(negedge i_clk);
   endtask : issue

   task automatic sizes(input int nb, input int nw, input int nbr);
      chk("beats", nb, bq.size());
      chk("writes", nw, wq.size());
      chk("branches", nbr, brq.size());
   endtask : sizes

   task automatic beat(input int k, input logic [31:0] a, input logic w, input logic u,
                       input logic [31:0] wd);
      lsm_pkg::size_t sz;
      sz = r.size;
      if (r.form == lsm_pkg::F_MULTI || r.form == lsm_pkg::F_TWO_WORD_LOAD) sz = lsm_pkg::SZ_WORD;
      chk("size", {30'h0, sz}, {30'h0, bq[k].size});
      chk("addr", a, bq[k].addr);
      chk("write", {31'h0, w}, {31'h0, bq[k].write});
      chk("unpriv", {31'h0, u}, {31'h0, bq[k].unpriv});
      if (w) chk("wdata", wd, bq[k].wdata);
   endtask : beat

   task automatic wr(input int k, input logic [3:0] idx, input logic [31:0] d);
      chk("wr_idx", {28'h0, idx}, {28'h0, wq[k].idx});
      chk("wr_data", d, wq[k].data);
   endtask : wr

   // Base is never the program counter, transfer register never SP or PC.
   task automatic t_unpriv;
      r = '0;
      r.amode = lsm_pkg::AM_UNPRIV;
      r.size = lsm_pkg::SZ_BYTE;
      r.signed_ld = 1'b1;
      r.privileged = 1'b1;
      r.xfer_idx = 4'h2;
      r.base_val = 32'h0000_0010;
      r.imm = 8'hff;
      put(32'h0000_010f, 32'h8000_0000);
      issue(2'h1);
      sizes(1, 1, 0);
      beat(0, 32'h0000_010f, 1'b0, 1'b1, 32'h0);
      wr(0, 4'h2, 32'hffff_ff80);
      r.size = lsm_pkg::SZ_HALF;
      r.signed_ld = 1'b0;
      r.privileged = 1'b0;
      r.imm = 8'h02;
      put(32'h0000_0012, 32'h9abc_0000);
      issue(2'h0);
      sizes(1, 1, 0);
      beat(0, 32'h0000_0012, 1'b0, 1'b1, 32'h0);
      wr(0, 4'h2, 32'h0000_9abc);
      r.form = lsm_pkg::F_SINGLE_STORE;
      r.size = lsm_pkg::SZ_WORD;
      r.privileged = 1'b1;
      r.xfer_idx = 4'h5;
      r.imm = 8'h00;
      r.base_val = 32'h0000_0020;
      issue(2'h2);
      sizes(1, 0, 0);
      beat(0, 32'h0000_0020, 1'b1, 1'b1, 32'hc0de_0005);
      $display("test unpriv done");
   endtask : t_unpriv

   task automatic t_regoff;
      r = '0;
      r.amode = lsm_pkg::AM_REGOFF;
      r.size = lsm_pkg::SZ_HALF;
      r.signed_ld = 1'b1;
      r.privileged = 1'b1;
      r.xfer_idx = 4'h3;
      r.base_val = 32'h0000_0040;
      r.offset_val = 32'h0000_0003;
      r.shift = 2'h3;
      put(32'h0000_0058, 32'h0000_8001);
      issue(2'h1);
      sizes(1, 1, 0);
      beat(0, 32'h0000_0058, 1'b0, 1'b0, 32'h0);
      wr(0, 4'h3, 32'hffff_8001);
      $display("test regoff done");
   endtask : t_regoff

   // Offsets are -4095, +64 and -1020; SP and PC only as word destinations.
   task automatic t_pcrel;
      r = '0;
      r.amode = lsm_pkg::AM_PCREL;
      r.size = lsm_pkg::SZ_BYTE;
      r.privileged = 1'b1;
      r.pc = 32'h0000_0200;
      r.pc_off = 13'h1001;
      put(32'hffff_f201, 32'h0000_a500);
      issue(2'h0);
      sizes(1, 1, 0);
      beat(0, 32'hffff_f201, 1'b0, 1'b0, 32'h0);
      wr(0, 4'h0, 32'h0000_00a5);
      r.size = lsm_pkg::SZ_WORD;
      r.xfer_idx = 4'hf;
      r.pc_off = 13'h0040;
      put(32'h0000_0240, 32'h0000_1235);
      issue(2'h2);
      sizes(1, 0, 1);
      chk("branch", 32'h0000_1234, brq[0]);
      r.form = lsm_pkg::F_TWO_WORD_LOAD;
      r.xfer_idx = 4'h6;
      r.xfer2_idx = 4'h7;
      r.pc_off = 13'h1c04;
      put(32'hffff_fe04, 32'h6666_0000);
      put(32'hffff_fe08, 32'h7777_0000);
      issue(2'h1);
      sizes(2, 2, 0);
      beat(0, 32'hffff_fe04, 1'b0, 1'b0, 32'h0);
      beat(1, 32'hffff_fe08, 1'b0, 1'b0, 32'h0);
      wr(0, 4'h6, 32'h6666_0000);
      wr(1, 4'h7, 32'h7777_0000);
      $display("test pcrel done");
   endtask : t_pcrel

   // Lists are non-empty and hold neither SP, PC nor the base register.
   task automatic t_multi;
      logic [11:0] ld_m;
      logic [11:0] db_m;
      logic [3:0] up [3];
      logic [3:0] bi;
      logic [3:0] id;
      logic [31:0] a;
      ld_m = 12'b1000_0001_1111;
      db_m = 12'b0111_0001_1000;
      up = '{4'h1, 4'h2, 4'h4};
      for (int c = 0; c < 12; c++) begin
         r = '0;
         r.form = lsm_pkg::F_MULTI;
         r.multi = lsm_pkg::multi_t'(c);
         r.privileged = 1'b1;
         r.base_idx = 4'h3;
         r.base_val = 32'h0000_0100;
         r.reglist = 16'h0016;
         r.writeback = 1'b1;
         for (int k = 0; k < 5; k++) put(32'hf8 + 32'(4 * k), 32'h1000_00f8 + 32'(4 * k));
         bi = (c >= 10) ? 4'hd : 4'h3;
         issue(2'(c % 3));
         sizes(3, ld_m[c] ? 4 : 1, 0);
         for (int k = 0; k < 3; k++) begin
            id = db_m[c] ? up[2 - k] : up[k];
            a = db_m[c] ? 32'h100 - 32'(4 * k) : 32'h100 + 32'(4 * k);
            beat(k, a, !ld_m[c], 1'b0, {28'hc0de000, id});
            if (ld_m[c]) wr(k, id, 32'h1000_0000 | a);
         end
         wr(ld_m[c] ? 3 : 0, bi, db_m[c] ? 32'hf8 : 32'h108);
      end
      $display("test multi done");
   endtask : t_multi

   task automatic t_pop_pc;
      r = '0;
      r.form = lsm_pkg::F_MULTI;
      r.multi = lsm_pkg::MT_STACK_RESTORE;
      r.privileged = 1'b1;
      r.base_val = 32'h0000_0180;
      r.reglist = 16'h8010;
      put(32'h0000_0180, 32'h4444_0000);
      put(32'h0000_0184, 32'h0000_0301);
      issue(2'h1);
      sizes(2, 2, 1);
      beat(0, 32'h0000_0180, 1'b0, 1'b0, 32'h0);
      beat(1, 32'h0000_0184, 1'b0, 1'b0, 32'h0);
      wr(0, 4'h4, 32'h4444_0000);
      wr(1, 4'hd, 32'h0000_0184);
      chk("branch", 32'h0000_0300, brq[0]);
      $display("test pop_pc done");
   endtask : t_pop_pc

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : wrap_up

   initial begin
      repeat (4) @(negedge i_clk);
      i_rst_n = 1'b1;
      t_unpriv();
      t_regoff();
      t_pcrel();
      t_multi();
      t_pop_pc();
      wrap_up();
   end

   initial begin
      #200000;
      mismatches++;
      wrap_up();
   end
endmodule : load_store_multiple_exec_tb_top
`default_nettype wire
